/* File: hdl/mpc_pkg.sv */
package mpc_pkg;

  // Page counter range and width.
  localparam int PAGE_W = 10;
  localparam logic [9:0] MAX_PAGE = 10'h3FF;
  localparam logic [9:0] MIN_PAGE = 10'h001;
  localparam logic [9:0] ZERO_PAGE = 10'h000;

  // Counter control code encodings.
  localparam logic [1:0] CCC_RESET = 2'h1;
  localparam logic [1:0] CCC_INCR = 2'h2;

  // Reservation field encodings.
  localparam logic [1:0] RSV_NOT = 2'h0;
  localparam logic [1:0] RSV_YES = 2'h3;

  // Reset value of the reserved-page threshold.
  localparam logic [9:0] RSV_PAGES_RST = 10'h000;

  // Head machine states.
  typedef enum logic {
    MPC_HD_DIS = 1'b0,
    MPC_HD_EN = 1'b1
  } mpc_head_st_t;

  // Per-bus machine states, Gray along idle, below, equal.
  typedef enum logic [1:0] {
    MPC_BS_IDLE = 2'h0,
    MPC_BS_BELOW = 2'h1,
    MPC_BS_EQUAL = 2'h3
  } mpc_bus_st_t;

  // Allocation field subfields as carried on a bus.
  typedef struct packed {
    logic [1:0] ccc;
    logic [1:0] rsv;
    logic [1:0] modulus;
  } mpc_field_t;

  // State of one per-bus machine.
  typedef struct packed {
    mpc_bus_st_t st;
    logic [9:0] cnt;
    logic [9:0] use_cnt;
    logic use_vld;
    mpc_field_t fwd;
    logic fwd_vld;
  } mpc_bus_state_t;

  // State of the head generator.
  typedef struct packed {
    mpc_head_st_t st;
    logic [9:0] cnt;
    logic [9:0] rsv_pages;
    mpc_field_t gen;
    logic gen_vld;
  } mpc_head_state_t;

endpackage : mpc_pkg

/* File: hdl/mpc_page_counter.sv */
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Head allocation enabled only while sending and receiving stable head-of-bus status.
// - Enabled, counter below max: empty octet gets increment, counter advances.
// - Enabled, counter at max: empty octet gets reset, counter loads one.
// - Enabled then disabled: next octet gets reset, counter zero, go disabled.
// - Head disabled at power-up, on waiting status, or software disable.
// - Disabled then enabled: next octet gets reset, counter one, go enabled.
// - Disabled without enable: each empty octet gets increment.
// - Reservation marked reserved when counter not above reserved-page value.
// - Reserved-page value powers up at zero.
// - Reservation and modulus use counter value before the octet's update.
// - Modulus subfield is counter modulo four, zero when disabled.
// - Per-bus machines forward control and modulus subfields unchanged.
// - Reset is 01, increment 10; 00 and 11 are error codes.
// - Per-bus machines start idle and keep one counter each.
// - Reservation use and modulus check precede the counter update.
// - Counter offered to page functions only when above zero.
// - Below: modulus mismatch or reset clears counter and goes idle.
// - Below: match with increment or error advances; reaching max goes equal.
// - Equal: match with reset loads one and returns below.
// - Updated counter serves the next field on that bus.
// - Per-bus transitions only on a received field.
// - Equal: mismatch, increment or error clears counter and goes idle.
// - Idle: reset loads one and goes below; other codes stay idle.

////////////////////////////////////////////////////////////////////////////////
// Per-bus page counter machine.
module mpc_bus_counter (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic field_vld,
  input wire mpc_pkg::mpc_field_t field_in,
  output mpc_pkg::mpc_field_t field_out,
  output logic field_out_vld,
  output logic [9:0] bus_page_counter,
  output logic [9:0] page_for_field,
  output logic page_for_field_vld,
  output mpc_pkg::mpc_bus_st_t fsm_state
);

  mpc_pkg::mpc_bus_state_t s;
  mpc_pkg::mpc_bus_state_t next_s;
  logic mod_ok;

  assign mod_ok = (field_in.modulus == s.cnt[1:0]);

  // Next-state logic; counter and state move only on a received field, the valid flags clear without one.
  always_comb
  begin
    next_s = s;
    next_s.fwd_vld = field_vld;
    next_s.use_vld = 1'b0;
    if (field_vld)
    begin
      next_s.fwd = field_in;
      next_s.use_cnt = s.cnt;
      next_s.use_vld = (s.cnt != mpc_pkg::ZERO_PAGE);
      case (s.st)
        mpc_pkg::MPC_BS_BELOW:
        begin
          if (!mod_ok || field_in.ccc == mpc_pkg::CCC_RESET)
          begin
            next_s.cnt = mpc_pkg::ZERO_PAGE;
            next_s.st = mpc_pkg::MPC_BS_IDLE;
          end
          else
          begin
            next_s.cnt = s.cnt + 10'h001;
            if (s.cnt + 10'h001 == mpc_pkg::MAX_PAGE)
              next_s.st = mpc_pkg::MPC_BS_EQUAL;
          end
        end
        mpc_pkg::MPC_BS_EQUAL:
        begin
          if (mod_ok && field_in.ccc == mpc_pkg::CCC_RESET)
          begin
            next_s.cnt = mpc_pkg::MIN_PAGE;
            next_s.st = mpc_pkg::MPC_BS_BELOW;
          end
          else
          begin
            next_s.cnt = mpc_pkg::ZERO_PAGE;
            next_s.st = mpc_pkg::MPC_BS_IDLE;
          end
        end
        default:
        begin
          // idle waits for the reset code
          if (field_in.ccc == mpc_pkg::CCC_RESET)
          begin
            next_s.cnt = mpc_pkg::MIN_PAGE;
            next_s.st = mpc_pkg::MPC_BS_BELOW;
          end
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      s <= '0;
    else
      s <= next_s;
  end

  // updated counter visible for the next field
  assign bus_page_counter = s.cnt;
  assign page_for_field = s.use_cnt;
  assign page_for_field_vld = s.use_vld;
  assign field_out = s.fwd;
  assign field_out_vld = s.fwd_vld;
  assign fsm_state = s.st;

  property p_below_reset;
    @(posedge core_clk) disable iff (!rstn)
    (field_vld && s.st == mpc_pkg::MPC_BS_BELOW && field_in.ccc == mpc_pkg::CCC_RESET)
    |=> (s.st == mpc_pkg::MPC_BS_IDLE && s.cnt == mpc_pkg::ZERO_PAGE);
  endproperty
  a_below_reset: assert property (p_below_reset) else $error("below did not clear on reset");

  property p_below_incr;
    @(posedge core_clk) disable iff (!rstn)
    (field_vld && s.st == mpc_pkg::MPC_BS_BELOW && mod_ok
     && field_in.ccc != mpc_pkg::CCC_RESET)
    |=> (s.cnt == $past(s.cnt) + 10'h001);
  endproperty
  a_below_incr: assert property (p_below_incr) else $error("below did not advance");

  property p_equal_reset;
    @(posedge core_clk) disable iff (!rstn)
    (field_vld && s.st == mpc_pkg::MPC_BS_EQUAL && mod_ok && field_in.ccc == mpc_pkg::CCC_RESET)
    |=> (s.st == mpc_pkg::MPC_BS_BELOW && s.cnt == mpc_pkg::MIN_PAGE);
  endproperty
  a_equal_reset: assert property (p_equal_reset) else $error("equal did not reload one");

  property p_equal_lost;
    @(posedge core_clk) disable iff (!rstn)
    (field_vld && s.st == mpc_pkg::MPC_BS_EQUAL && !(mod_ok && field_in.ccc == mpc_pkg::CCC_RESET))
    |=> (s.st == mpc_pkg::MPC_BS_IDLE && s.cnt == mpc_pkg::ZERO_PAGE);
  endproperty
  a_equal_lost: assert property (p_equal_lost) else $error("equal did not go idle");

  property p_idle_stay;
    @(posedge core_clk) disable iff (!rstn)
    (field_vld && s.st == mpc_pkg::MPC_BS_IDLE && field_in.ccc != mpc_pkg::CCC_RESET)
    |=> (s.st == mpc_pkg::MPC_BS_IDLE);
  endproperty
  a_idle_stay: assert property (p_idle_stay) else $error("idle left without reset");

  property p_quiet;
    @(posedge core_clk) disable iff (!rstn)
    !field_vld |=> ($stable(s.cnt) && $stable(s.st));
  endproperty
  a_quiet: assert property (p_quiet) else $error("counter moved without a field");

  property p_forward;
    @(posedge core_clk) disable iff (!rstn)
    field_vld |=> (field_out_vld && field_out.ccc == $past(field_in.ccc)
                   && field_out.modulus == $past(field_in.modulus));
  endproperty
  a_forward: assert property (p_forward) else $error("subfield not forwarded unchanged");

endmodule : mpc_bus_counter

////////////////////////////////////////////////////////////////////////////////
// Head generator plus one counter machine per bus.
module mpc_page_counter (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic head_of_bus_status_tx_stable,
  input wire logic head_of_bus_status_rx_stable,
  input wire logic head_of_bus_status_tx_waiting,
  input wire logic head_of_bus_status_rx_waiting,
  input wire logic sw_alloc_disable,
  input wire logic rsv_pages_wr,
  input wire logic [9:0] rsv_pages_wdata,
  input wire logic empty_octet_vld,
  output mpc_pkg::mpc_field_t gen_field,
  output logic gen_field_vld,
  output logic [9:0] head_page_counter,
  output logic head_enabled,
  output logic [9:0] rsv_pages,
  input wire logic [1:0] bus_field_vld,
  input wire mpc_pkg::mpc_field_t [1:0] bus_field_in,
  output mpc_pkg::mpc_field_t [1:0] bus_field_out,
  output logic [1:0] bus_field_out_vld,
  output logic [1:0][9:0] bus_page_counter,
  output logic [1:0][9:0] page_for_field,
  output logic [1:0] page_for_field_vld,
  output mpc_pkg::mpc_bus_st_t [1:0] bus_fsm_state
);

  mpc_pkg::mpc_head_state_t h;
  mpc_pkg::mpc_head_state_t next_h;
  logic [1:0] sync_q1;
  logic [1:0] sync_q2;
  logic alloc_en;

  // Stable head-of-bus status arrives from the link side; two stages first. Waiting status is used directly.
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      sync_q1 <= 2'h0;
      sync_q2 <= 2'h0;
    end
    else
    begin
      sync_q1 <= {head_of_bus_status_tx_stable, head_of_bus_status_rx_stable};
      sync_q2 <= sync_q1;
    end
  end

  // both stable, waiting status or software disables.
  assign alloc_en = (&sync_q2) && !sw_alloc_disable
                    && !head_of_bus_status_tx_waiting && !head_of_bus_status_rx_waiting;

  // Head generator next state.
  always_comb
  begin
    next_h = h;
    next_h.gen_vld = empty_octet_vld;
    if (rsv_pages_wr)
      next_h.rsv_pages = rsv_pages_wdata;
    if (empty_octet_vld)
    begin
      // subfields from pre-update counter; reservation compare
      next_h.gen.rsv = (h.cnt <= h.rsv_pages) ? mpc_pkg::RSV_YES : mpc_pkg::RSV_NOT;
      next_h.gen.modulus = h.cnt[1:0];
      case (h.st)
        mpc_pkg::MPC_HD_EN:
        begin
          if (!alloc_en)
          begin
            next_h.gen.ccc = mpc_pkg::CCC_RESET;
            next_h.cnt = mpc_pkg::ZERO_PAGE;
            next_h.st = mpc_pkg::MPC_HD_DIS;
          end
          else if (h.cnt == mpc_pkg::MAX_PAGE)
          begin
            next_h.gen.ccc = mpc_pkg::CCC_RESET;
            next_h.cnt = mpc_pkg::MIN_PAGE;
          end
          else
          begin
            next_h.gen.ccc = mpc_pkg::CCC_INCR;
            next_h.cnt = h.cnt + 10'h001;
          end
        end
        default:
        begin
          if (alloc_en)
          begin
            next_h.gen.ccc = mpc_pkg::CCC_RESET;
            next_h.cnt = mpc_pkg::MIN_PAGE;
            next_h.st = mpc_pkg::MPC_HD_EN;
          end
          else
          begin
            next_h.gen.ccc = mpc_pkg::CCC_INCR;
          end
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      h <= '{st: mpc_pkg::MPC_HD_DIS, cnt: mpc_pkg::ZERO_PAGE,
             rsv_pages: mpc_pkg::RSV_PAGES_RST, gen: '0, gen_vld: 1'b0};
    else
      h <= next_h;
  end

  assign gen_field = h.gen;
  assign gen_field_vld = h.gen_vld;
  assign head_page_counter = h.cnt;
  assign head_enabled = (h.st == mpc_pkg::MPC_HD_EN);
  assign rsv_pages = h.rsv_pages;

  // one ten-bit counter machine per bus
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_bus
      mpc_bus_counter u_bus (
        .core_clk(core_clk),
        .rstn(rstn),
        .field_vld(bus_field_vld[gi]),
        .field_in(bus_field_in[gi]),
        .field_out(bus_field_out[gi]),
        .field_out_vld(bus_field_out_vld[gi]),
        .bus_page_counter(bus_page_counter[gi]),
        .page_for_field(page_for_field[gi]),
        .page_for_field_vld(page_for_field_vld[gi]),
        .fsm_state(bus_fsm_state[gi])
      );
    end
  endgenerate

  property p_head_incr;
    @(posedge core_clk) disable iff (!rstn)
    (empty_octet_vld && h.st == mpc_pkg::MPC_HD_EN && alloc_en && h.cnt != mpc_pkg::MAX_PAGE)
    |=> (gen_field.ccc == mpc_pkg::CCC_INCR && h.cnt == $past(h.cnt) + 10'h001);
  endproperty
  a_head_incr: assert property (p_head_incr) else $error("head did not increment");

  property p_head_wrap;
    @(posedge core_clk) disable iff (!rstn)
    (empty_octet_vld && h.st == mpc_pkg::MPC_HD_EN && alloc_en && h.cnt == mpc_pkg::MAX_PAGE)
    |=> (gen_field.ccc == mpc_pkg::CCC_RESET && h.cnt == mpc_pkg::MIN_PAGE);
  endproperty
  a_head_wrap: assert property (p_head_wrap) else $error("head did not wrap");

  property p_head_dis;
    @(posedge core_clk) disable iff (!rstn)
    (empty_octet_vld && h.st == mpc_pkg::MPC_HD_EN && !alloc_en)
    |=> (gen_field.ccc == mpc_pkg::CCC_RESET && h.cnt == mpc_pkg::ZERO_PAGE && !head_enabled);
  endproperty
  a_head_dis: assert property (p_head_dis) else $error("head did not disable");

  property p_head_mod;
    @(posedge core_clk) disable iff (!rstn)
    empty_octet_vld |=> (gen_field.modulus == $past(h.cnt[1:0]));
  endproperty
  a_head_mod: assert property (p_head_mod) else $error("modulus wrong");

  property p_head_rsv;
    @(posedge core_clk) disable iff (!rstn)
    empty_octet_vld |=> (gen_field.rsv == (($past(h.cnt) <= $past(h.rsv_pages))
                         ? mpc_pkg::RSV_YES : mpc_pkg::RSV_NOT));
  endproperty
  a_head_rsv: assert property (p_head_rsv) else $error("reservation wrong");

endmodule : mpc_page_counter
`default_nettype wire

/* File: sim/mpc_bus_node.sv */
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Upstream node model that puts one allocation field per request on a bus lane.
module mpc_bus_node (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic [1:0] req,
  input wire mpc_pkg::mpc_field_t req_field,
  output logic [1:0] vld,
  output mpc_pkg::mpc_field_t [1:0] field
);
  // Between fields a lane alternates each cycle between the inverse of its last field and that field, so a stale read is seen.
  // code encodings sent as given
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      vld <= 2'h0;
      field <= {6'h15, 6'h2A};
    end
    else
    begin
      for (int b = 0; b < 2; b++)
      begin
        vld[b] <= req[b];
        field[b] <= req[b] ? req_field : ~field[b];
      end
    end
  end
endmodule : mpc_bus_node
`default_nettype wire

/* File: sim/tb_mpc_page_counter.sv */
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Self-checking bench for the head generator and the per-bus counters.
module tb_mpc_page_counter;
  logic core_clk, rstn, tx_st, rx_st, tx_w, rx_w, sw_dis, rsv_wr, oct;
  logic [9:0] rsv_wd, head_cnt, rsv_pages;
  logic gen_vld, head_en;
  logic [1:0] req, bvld, out_vld, pf_vld;
  mpc_pkg::mpc_field_t req_f, gen_f;
  mpc_pkg::mpc_field_t [1:0] bin, bout;
  logic [1:0][9:0] bcnt, pf;
  mpc_pkg::mpc_bus_st_t [1:0] bst;
  int miscompares, compares;
  // Expected counters, kept from the rules so that no expectation is read back from the design.
  logic [9:0] exp_head;
  logic [1:0][9:0] exp_bcnt;

  // Clock, period 5 ns.
  initial
  begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  mpc_bus_node node (.core_clk(core_clk), .rstn(rstn), .req(req), .req_field(req_f),
    .vld(bvld), .field(bin));

  mpc_page_counter dut (.core_clk(core_clk), .rstn(rstn), .head_of_bus_status_tx_stable(tx_st),
    .head_of_bus_status_rx_stable(rx_st), .head_of_bus_status_tx_waiting(tx_w),
    .head_of_bus_status_rx_waiting(rx_w), .sw_alloc_disable(sw_dis), .rsv_pages_wr(rsv_wr),
    .rsv_pages_wdata(rsv_wd), .empty_octet_vld(oct), .gen_field(gen_f),
    .gen_field_vld(gen_vld), .head_page_counter(head_cnt), .head_enabled(head_en),
    .rsv_pages(rsv_pages), .bus_field_vld(bvld), .bus_field_in(bin), .bus_field_out(bout),
    .bus_field_out_vld(out_vld), .bus_page_counter(bcnt), .page_for_field(pf),
    .page_for_field_vld(pf_vld), .bus_fsm_state(bst));

  // Compares one value against its expectation.
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp)
    begin
      miscompares++;
      $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : chk

  // Prints the counts and the verdict, then ends the run.
  task automatic tally_and_finish;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : tally_and_finish

  // One empty octet; checks the generated field, counter and state.
  task automatic octet(input logic [1:0] c, input logic [1:0] r, input logic [9:0] cnt,
    input logic en);
    logic [1:0] m;
    m = exp_head[1:0];
    @(posedge core_clk);
    #1 oct = 1'b1;
    @(posedge core_clk);
    #1 oct = 1'b0;
    chk({15'h0, gen_vld}, 16'h1);
    chk({10'h0, gen_f}, {10'h0, c, r, m});
    chk({6'h0, head_cnt}, {6'h0, cnt});
    chk({15'h0, head_en}, {15'h0, en});
    exp_head = cnt;
  endtask : octet

  // One field on bus b; checks forwarding, pre-update page and counter.
  task automatic send(input int b, input logic [1:0] c, input logic [1:0] m,
    input logic pv, input logic [9:0] cnt, input logic [1:0] st);
    logic [9:0] pg;
    pg = exp_bcnt[b];
    @(posedge core_clk);
    #1 req[b] = 1'b1;
    req_f = {c, 2'h0, m};
    @(posedge core_clk);
    #1 req = 2'h0;
    @(posedge core_clk);
    #1;
    chk({15'h0, out_vld[b]}, 16'h1);
    chk({12'h0, bout[b].ccc, bout[b].modulus}, {12'h0, c, m});
    chk({15'h0, pf_vld[b]}, {15'h0, pv});
    if (pv)
      chk({6'h0, pf[b]}, {6'h0, pg});
    chk({6'h0, bcnt[b]}, {6'h0, cnt});
    chk({14'h0, bst[b]}, {14'h0, st});
    exp_bcnt[b] = cnt;
  endtask : send

  // Climbs bus b with matching increments until the counter holds the maximum.
  task automatic climb(input int b, input int from);
    for (int c = from; c < 1023; c++)
      send(b, mpc_pkg::CCC_INCR, c[1:0], 1'b1, 10'(c + 1),
        (c == 1022) ? mpc_pkg::MPC_BS_EQUAL : mpc_pkg::MPC_BS_BELOW);
  endtask : climb

  // Head generator from power-up through enable, wrap, disable and waiting.
  task automatic t_head;
    logic [9:0] c;
    chk({6'h0, rsv_pages}, 16'h0);
    octet(mpc_pkg::CCC_INCR, mpc_pkg::RSV_YES, 10'h0, 1'b0);
    tx_st = 1'b1;
    rx_st = 1'b1;
    rsv_wd = 10'h002;
    rsv_wr = 1'b1;
    @(posedge core_clk);
    #1 rsv_wr = 1'b0;
    repeat (4) @(posedge core_clk);
    #1 chk({6'h0, rsv_pages}, 16'h2);
    octet(mpc_pkg::CCC_RESET, mpc_pkg::RSV_YES, 10'h1, 1'b1);
    for (int i = 1; i < 1023; i++)
    begin
      c = 10'(i);
      octet(mpc_pkg::CCC_INCR, (c <= 10'h2) ? mpc_pkg::RSV_YES : mpc_pkg::RSV_NOT,
        c + 10'h1, 1'b1);
    end
    octet(mpc_pkg::CCC_RESET, mpc_pkg::RSV_NOT, 10'h1, 1'b1);
    sw_dis = 1'b1;
    octet(mpc_pkg::CCC_RESET, mpc_pkg::RSV_YES, 10'h0, 1'b0);
    sw_dis = 1'b0;
    octet(mpc_pkg::CCC_RESET, mpc_pkg::RSV_YES, 10'h1, 1'b1);
    rx_w = 1'b1;
    octet(mpc_pkg::CCC_RESET, mpc_pkg::RSV_YES, 10'h0, 1'b0);
    octet(mpc_pkg::CCC_INCR, mpc_pkg::RSV_YES, 10'h0, 1'b0);
    rx_w = 1'b0;
    rx_st = 1'b0;
    repeat (3) @(posedge core_clk);
    octet(mpc_pkg::CCC_INCR, mpc_pkg::RSV_YES, 10'h0, 1'b0);
    rx_st = 1'b1;
    tx_w = 1'b1;
    repeat (3) @(posedge core_clk);
    octet(mpc_pkg::CCC_INCR, mpc_pkg::RSV_YES, 10'h0, 1'b0);
    tx_w = 1'b0;
    $display("test head done");
  endtask : t_head

  // Per-bus machines: idle codes, mismatch, error, wrap and equal exits.
  task automatic t_bus;
    send(0, mpc_pkg::CCC_INCR, 2'h0, 1'b0, 10'h0, mpc_pkg::MPC_BS_IDLE);
    send(0, 2'h3, 2'h0, 1'b0, 10'h0, mpc_pkg::MPC_BS_IDLE);
    send(0, mpc_pkg::CCC_RESET, 2'h0, 1'b0, 10'h1, mpc_pkg::MPC_BS_BELOW);
    send(0, mpc_pkg::CCC_INCR, 2'h1, 1'b1, 10'h2, mpc_pkg::MPC_BS_BELOW);
    send(0, mpc_pkg::CCC_INCR, 2'h0, 1'b1, 10'h0, mpc_pkg::MPC_BS_IDLE);
    send(0, mpc_pkg::CCC_RESET, 2'h0, 1'b0, 10'h1, mpc_pkg::MPC_BS_BELOW);
    send(0, mpc_pkg::CCC_RESET, 2'h1, 1'b1, 10'h0, mpc_pkg::MPC_BS_IDLE);
    send(0, mpc_pkg::CCC_RESET, 2'h0, 1'b0, 10'h1, mpc_pkg::MPC_BS_BELOW);
    send(0, 2'h0, 2'h1, 1'b1, 10'h2, mpc_pkg::MPC_BS_BELOW);
    climb(0, 2);
    send(0, mpc_pkg::CCC_RESET, 2'h3, 1'b1, 10'h1, mpc_pkg::MPC_BS_BELOW);
    send(1, mpc_pkg::CCC_RESET, 2'h0, 1'b0, 10'h1, mpc_pkg::MPC_BS_BELOW);
    climb(1, 1);
    send(1, mpc_pkg::CCC_INCR, 2'h3, 1'b1, 10'h0, mpc_pkg::MPC_BS_IDLE);
    repeat (10) @(posedge core_clk);
    #1 chk({6'h0, bcnt[0]}, 16'h1);
    chk({14'h0, bst[0]}, {14'h0, mpc_pkg::MPC_BS_BELOW});
    $display("test bus done");
  endtask : t_bus

  // Watchdog sized well above the expected run of some 8,300 cycles.
  initial
  begin
    #200000;
    miscompares++;
    tally_and_finish();
  end

  // Reset, then the scenarios.
  initial
  begin
    {rstn, tx_st, rx_st, tx_w, rx_w, sw_dis, rsv_wr, oct} = 8'h00;
    rsv_wd = 10'h000;
    req = 2'h0;
    req_f = 6'h00;
    miscompares = 0;
    compares = 0;
    exp_head = 10'h000;
    exp_bcnt = '0;
    repeat (8) @(posedge core_clk);
    #1 rstn = 1'b1;
    chk({15'h0, head_en}, 16'h0);
    chk({12'h0, bst[1], bst[0]}, 16'h0);
    t_head();
    t_bus();
    tally_and_finish();
  end
endmodule : tb_mpc_page_counter
`default_nettype wire
